/* src/sslc_pkg.sv */
// package: register map and field layout of the link test and clock control block
package sslc_pkg;
  localparam logic [7:0] LINK_CTRL_ADDR = 8'h04;
  localparam int TEST_MODE_BIT = 7;
  localparam int LOCAL_LOOP_BIT = 5;
  localparam int REMOTE_LOOP_BIT = 4;
  localparam int RX_CLK_EN_BIT = 3;
  localparam int TX_CLK_EN_BIT = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // interrupt source selector value that picks the test mode input
  localparam logic [1:0] INT_SEL_TEST_MODE = 2'h3;
endpackage

/* src/sslc_link_control.sv */
// link control: loopback outputs, clock direction and modem line routing by strapped role
//
// Chosen here: the strobed register port and the placing of the registers.
module sslc_link_control (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // board straps
  input wire logic role_is_dce,
  input wire logic sync_jumper_fitted,
  input wire logic [1:0] int_source_select,
  // test lines at the connector
  output logic local_loopback_request,
  output logic remote_loopback_request,
  input wire logic test_mode_indication,
  output logic test_mode_interrupt,
  // serial controller sync input of channel a
  output logic chan_a_sync_input,
  // element clocks: serial controller side
  input wire logic chan_a_clock_pin_in,
  output logic chan_a_clock_pin_out,
  output logic chan_a_clock_pin_oe,
  input wire logic chan_b_clock_pin_in,
  output logic chan_b_clock_pin_oe,
  output logic receive_clock_pins,
  // element clocks: link side
  input wire logic link_tx_clock_in,
  output logic link_tx_clock_out,
  output logic link_tx_clock_oe,
  input wire logic link_rx_clock_in,
  output logic link_rx_clock_out,
  output logic link_rx_clock_oe,
  // modem lines: serial controller side
  input wire logic chan_a_request_output,
  input wire logic chan_a_ready_request_pin,
  input wire logic chan_b_ready_request_pin,
  output logic chan_a_clear_input,
  output logic chan_a_carrier_input,
  output logic chan_b_carrier_input,
  // modem lines: link side
  output logic link_rts_out,
  output logic link_dtr_out,
  output logic link_cts_out,
  output logic link_dsr_out,
  output logic link_cd_out,
  input wire logic link_rts_in,
  input wire logic link_dtr_in,
  input wire logic link_cts_in,
  input wire logic link_dsr_in,
  input wire logic link_cd_in
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] tm_sync_ff;
  logic [1:0] nxt_tm_sync;
  logic [1:0] role_sync_ff;
  logic [1:0] nxt_role_sync;
  logic role_is_dce_ff;
  logic nxt_role_is_dce;

  always_comb begin
    nxt_tm_sync = {tm_sync_ff[0], test_mode_indication};
    nxt_role_sync = {role_sync_ff[0], role_is_dce};
    // role strap synchronised and registered every cycle, so it follows the strap three clocks later
    nxt_role_is_dce = role_sync_ff[1];
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tm_sync_ff <= 2'h0;
      role_sync_ff <= 2'h0;
      role_is_dce_ff <= 1'b0;
    end else begin
      tm_sync_ff <= nxt_tm_sync;
      role_sync_ff <= nxt_role_sync;
      role_is_dce_ff <= nxt_role_is_dce;
    end
  end

  // ----------------------------------------------------------------
  // link control register
  // ----------------------------------------------------------------
  logic local_loop_ff;
  logic remote_loop_ff;
  logic rx_clk_en_ff;
  logic tx_clk_en_ff;
  logic [7:0] rdata_ff;
  logic nxt_local_loop;
  logic nxt_remote_loop;
  logic nxt_rx_clk_en;
  logic nxt_tx_clk_en;
  logic [7:0] nxt_rdata;
  logic hit;

  function automatic logic is_link_ctrl(input logic [7:0] addr);
    return addr == sslc_pkg::LINK_CTRL_ADDR;
  endfunction

  always_comb begin
    hit = is_link_ctrl(reg_addr);
    nxt_local_loop = local_loop_ff;
    nxt_remote_loop = remote_loop_ff;
    nxt_rx_clk_en = rx_clk_en_ff;
    nxt_tx_clk_en = tx_clk_en_ff;
    if (reg_write && hit) begin
      nxt_local_loop = reg_wdata[sslc_pkg::LOCAL_LOOP_BIT];
      nxt_remote_loop = reg_wdata[sslc_pkg::REMOTE_LOOP_BIT];
      nxt_rx_clk_en = reg_wdata[sslc_pkg::RX_CLK_EN_BIT];
      nxt_tx_clk_en = reg_wdata[sslc_pkg::TX_CLK_EN_BIT];
    end
    nxt_rdata = rdata_ff;
    if (reg_read) begin
      nxt_rdata = sslc_pkg::UNMAPPED_READ;
      if (hit) begin
        // bits 6, 1, 0 read zero
        nxt_rdata[sslc_pkg::TEST_MODE_BIT] = tm_sync_ff[1];
        nxt_rdata[sslc_pkg::LOCAL_LOOP_BIT] = local_loop_ff;
        nxt_rdata[sslc_pkg::REMOTE_LOOP_BIT] = remote_loop_ff;
        nxt_rdata[sslc_pkg::RX_CLK_EN_BIT] = rx_clk_en_ff;
        nxt_rdata[sslc_pkg::TX_CLK_EN_BIT] = tx_clk_en_ff;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {local_loop_ff, remote_loop_ff, rx_clk_en_ff, tx_clk_en_ff} <= sslc_pkg::CTRL_RESET;
      rdata_ff <= 8'h00;
    end else begin
      local_loop_ff <= nxt_local_loop;
      remote_loop_ff <= nxt_remote_loop;
      rx_clk_en_ff <= nxt_rx_clk_en;
      tx_clk_en_ff <= nxt_tx_clk_en;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // test lines, identical in both roles
  // ----------------------------------------------------------------
  assign local_loopback_request = local_loop_ff;
  assign remote_loopback_request = remote_loop_ff;
  assign chan_a_sync_input = sync_jumper_fitted & remote_loop_ff;
  assign test_mode_interrupt = (int_source_select == sslc_pkg::INT_SEL_TEST_MODE) & tm_sync_ff[1];

  // ----------------------------------------------------------------
  // element clock direction (clocks pass as wires, not resampled)
  // ----------------------------------------------------------------
  logic tx_drive;
  logic rx_drive;

  always_comb begin
    // dce always sources tx clock; dte by its enable bit
    tx_drive = role_is_dce_ff | tx_clk_en_ff;
    // dte never sources rx clock; dce by its enable bit
    rx_drive = role_is_dce_ff & rx_clk_en_ff;
  end

  assign chan_a_clock_pin_oe = ~tx_drive;
  assign chan_a_clock_pin_out = link_tx_clock_in;
  assign link_tx_clock_oe = tx_drive;
  assign link_tx_clock_out = chan_a_clock_pin_in;
  assign chan_b_clock_pin_oe = 1'b0;
  assign link_rx_clock_oe = rx_drive;
  assign link_rx_clock_out = chan_b_clock_pin_in;
  assign receive_clock_pins = rx_drive ? chan_b_clock_pin_in : link_rx_clock_in;

  // ----------------------------------------------------------------
  // modem line routing by role
  // ----------------------------------------------------------------
  always_comb begin
    link_rts_out = 1'b0;
    link_dtr_out = 1'b0;
    link_cts_out = 1'b0;
    link_dsr_out = 1'b0;
    link_cd_out = 1'b0;
    if (role_is_dce_ff) begin
      link_cts_out = chan_a_request_output;
      link_dsr_out = chan_a_ready_request_pin;
      link_cd_out = chan_b_ready_request_pin;
      chan_a_clear_input = link_rts_in;
      chan_a_carrier_input = link_dtr_in;
      chan_b_carrier_input = 1'b0;
    end else begin
      link_rts_out = chan_a_request_output;
      link_dtr_out = chan_a_ready_request_pin;
      chan_a_clear_input = link_cts_in;
      chan_a_carrier_input = link_cd_in;
      chan_b_carrier_input = link_dsr_in;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_local_loop_write: assert property (@(posedge clock) disable iff (reset)
    (reg_write && is_link_ctrl(reg_addr)) |=>
      local_loopback_request == $past(reg_wdata[sslc_pkg::LOCAL_LOOP_BIT]))
    else $error("local loopback not taken from write");
  a_remote_loop_write: assert property (@(posedge clock) disable iff (reset)
    (reg_write && is_link_ctrl(reg_addr)) |=>
      remote_loopback_request == $past(reg_wdata[sslc_pkg::REMOTE_LOOP_BIT]))
    else $error("remote loopback not taken from write");
  a_sync_follows_rl: assert property (@(posedge clock) disable iff (reset)
    chan_a_sync_input == (sync_jumper_fitted && remote_loopback_request))
    else $error("sync input wrong");
  a_dte_no_rx_drive: assert property (@(posedge clock) disable iff (reset)
    !role_is_dce_ff |-> !link_rx_clock_oe)
    else $error("dte drives rx clock");
  a_dce_tx_drive: assert property (@(posedge clock) disable iff (reset)
    role_is_dce_ff |-> (link_tx_clock_oe && !chan_a_clock_pin_oe))
    else $error("dce not driving tx clock");
  a_dte_tx_select: assert property (@(posedge clock) disable iff (reset)
    !role_is_dce_ff |-> (link_tx_clock_oe == tx_clk_en_ff))
    else $error("dte tx clock direction wrong");
  a_read_reserved: assert property (@(posedge clock) disable iff (reset)
    reg_read |=> (reg_rdata[6] == 1'b0 && reg_rdata[1:0] == 2'h0))
    else $error("reserved bits read nonzero");
  a_read_back: assert property (@(posedge clock) disable iff (reset)
    (reg_write && is_link_ctrl(reg_addr)) ##1 (reg_read && is_link_ctrl(reg_addr))
    |=> reg_rdata[5:2] == $past(reg_wdata[5:2], 2))
    else $error("read back mismatch");
  a_tm_interrupt: assert property (@(posedge clock) disable iff (reset)
    $rose(tm_sync_ff[1]) && int_source_select == sslc_pkg::INT_SEL_TEST_MODE |-> test_mode_interrupt)
    else $error("test mode interrupt missing");
  a_tm_unselected: assert property (@(posedge clock) disable iff (reset)
    (int_source_select != sslc_pkg::INT_SEL_TEST_MODE) |-> !test_mode_interrupt)
    else $error("test mode interrupt while unselected");
  a_dce_rx_select: assert property (@(posedge clock) disable iff (reset)
    role_is_dce_ff |-> (link_rx_clock_oe == rx_clk_en_ff))
    else $error("dce rx clock direction wrong");
  a_rx_out_source: assert property (@(posedge clock) disable iff (reset)
    link_rx_clock_oe |-> (link_rx_clock_out == chan_b_clock_pin_in))
    else $error("rx clock not sourced from channel b");
  a_chan_b_input: assert property (@(posedge clock) disable iff (reset)
    !chan_b_clock_pin_oe)
    else $error("channel b clock pin driven");
  a_rx_from_link: assert property (@(posedge clock) disable iff (reset)
    !link_rx_clock_oe |-> (receive_clock_pins == link_rx_clock_in))
    else $error("rx clock not taken from link");
  a_dte_tx_input: assert property (@(posedge clock) disable iff (reset)
    (!role_is_dce_ff && !tx_clk_en_ff) |-> (chan_a_clock_pin_oe && chan_a_clock_pin_out == link_tx_clock_in))
    else $error("dte tx clock not taken from link");
  a_tx_out_source: assert property (@(posedge clock) disable iff (reset)
    link_tx_clock_oe |-> (link_tx_clock_out == chan_a_clock_pin_in))
    else $error("tx clock not sourced from channel a");
  a_tx_one_way: assert property (@(posedge clock) disable iff (reset)
    link_tx_clock_oe != chan_a_clock_pin_oe)
    else $error("tx clock pin direction conflict");
  a_dte_modem: assert property (@(posedge clock) disable iff (reset)
    !role_is_dce_ff |-> (link_rts_out == chan_a_request_output && link_dtr_out == chan_a_ready_request_pin
      && chan_a_clear_input == link_cts_in && chan_a_carrier_input == link_cd_in
      && chan_b_carrier_input == link_dsr_in))
    else $error("dte modem routing wrong");
  a_dte_quiet: assert property (@(posedge clock) disable iff (reset)
    !role_is_dce_ff |-> !(link_cts_out || link_dsr_out || link_cd_out))
    else $error("dte drives dce modem lines");
  a_dce_modem_out: assert property (@(posedge clock) disable iff (reset)
    role_is_dce_ff |-> (link_cts_out == chan_a_request_output && link_dsr_out == chan_a_ready_request_pin
      && link_cd_out == chan_b_ready_request_pin))
    else $error("dce modem outputs wrong");
  a_dce_quiet: assert property (@(posedge clock) disable iff (reset)
    role_is_dce_ff |-> !(link_rts_out || link_dtr_out))
    else $error("dce drives dte modem lines");
  a_dce_cross: assert property (@(posedge clock) disable iff (reset)
    role_is_dce_ff |-> (chan_a_clear_input == link_rts_in && chan_a_carrier_input == link_dtr_in))
    else $error("dce crossing wrong");
  a_role_strap: assert property (@(posedge clock) disable iff (reset)
    (!$past(reset) && !$past(reset, 2) && !$past(reset, 3)) |-> (role_is_dce_ff == $past(role_is_dce, 3)))
    else $error("role does not follow strap");
  a_ctrl_hold: assert property (@(posedge clock) disable iff (reset)
    !(reg_write && is_link_ctrl(reg_addr)) |=>
      $stable({local_loop_ff, remote_loop_ff, rx_clk_en_ff, tx_clk_en_ff}))
    else $error("control bits changed without write");
  a_reset_clear: assert property (@(posedge clock) disable iff (reset)
    $past(reset) |-> ({local_loop_ff, remote_loop_ff, rx_clk_en_ff, tx_clk_en_ff} == sslc_pkg::CTRL_RESET
      && reg_rdata == 8'h00))
    else $error("register not cleared by reset");
  a_unmapped_read: assert property (@(posedge clock) disable iff (reset)
    (reg_read && !is_link_ctrl(reg_addr)) |=> (reg_rdata == sslc_pkg::UNMAPPED_READ))
    else $error("unmapped read not zero");
  a_tm_readback: assert property (@(posedge clock) disable iff (reset)
    (reg_read && is_link_ctrl(reg_addr)) |=> (reg_rdata[sslc_pkg::TEST_MODE_BIT] == $past(tm_sync_ff[1])))
    else $error("test mode status not read back");

endmodule

/* test/sslc_peer_model.sv */
// peer model: link partner that sources both element clocks while a transfer runs
module sslc_peer_model (
  // control
  input wire logic run,
  // element clocks toward the block
  output logic tx_clock,
  output logic rx_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  // clocks stand still while no transfer runs; rx is kept out of phase with tx
  initial begin
    tx_clock = 1'b0;
    rx_clock = 1'b1;
    forever begin
      #160;
      if (run) begin
        tx_clock = ~tx_clock;
        rx_clock = ~tx_clock;
      end
    end
  end
endmodule

/* test/sync_serial_link_control_tb.sv */
// testbench: register access, role straps, clock direction and modem line routing
module sync_serial_link_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A = sslc_pkg::LINK_CTRL_ADDR;
  logic clock, reset, reg_write, reg_read, role_is_dce, sync_jumper_fitted, test_mode_indication, run;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mdrv;
  logic [1:0] int_source_select;
  logic [1:0] cdrv;
  logic local_loopback_request, remote_loopback_request, test_mode_interrupt, chan_a_sync_input;
  logic chan_a_clock_pin_in, chan_a_clock_pin_out, chan_a_clock_pin_oe, chan_b_clock_pin_in, chan_b_clock_pin_oe;
  logic receive_clock_pins, link_tx_clock_in, link_tx_clock_out, link_tx_clock_oe;
  logic link_rx_clock_in, link_rx_clock_out, link_rx_clock_oe;
  logic chan_a_request_output, chan_a_ready_request_pin, chan_b_ready_request_pin, chan_a_clear_input;
  logic chan_a_carrier_input, chan_b_carrier_input, link_rts_out, link_dtr_out, link_cts_out, link_dsr_out;
  logic link_cd_out, link_rts_in, link_dtr_in, link_cts_in, link_dsr_in, link_cd_in;
  int n_errors = 0;
  int samples_checked = 0;
  assign {chan_a_request_output, chan_a_ready_request_pin, chan_b_ready_request_pin, link_rts_in, link_dtr_in,
    link_cts_in, link_dsr_in, link_cd_in} = mdrv;
  assign {chan_a_clock_pin_in, chan_b_clock_pin_in} = cdrv;
  sslc_link_control i_dut (.*);
  sslc_peer_model i_peer (.run(run), .tx_clock(link_tx_clock_in), .rx_clock(link_rx_clock_in));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("rdata", reg_rdata, exp);
  endtask
  // write strobe followed at once by a read strobe of the same register
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("rdata", reg_rdata, exp);
  endtask
  task automatic clk_oe(input logic [7:0] d, input logic [3:0] oe);
    wr(A, d);
    chk("oe", {4'h0, chan_a_clock_pin_oe, link_tx_clock_oe, link_rx_clock_oe, chan_b_clock_pin_oe}, {4'h0, oe});
  endtask
  // one-hot walk over modem inputs; chan b carrier is tied low in the dce role and masked from the check
  task automatic route(input logic dce);
    logic [7:0] p;
    logic [7:0] e;
    run = 1'b1;
    for (int i = 0; i < 8; i++) begin
      p = 8'h01 << i;
      @(posedge clock);
      mdrv <= p;
      cdrv <= 2'(i);
      @(posedge clock);
      #1;
      e = dce ? {2'b00, p[7:3], 1'b0} : {p[7:6], 3'b000, p[2], p[0], p[1]};
      chk("route", {link_rts_out, link_dtr_out, link_cts_out, link_dsr_out, link_cd_out, chan_a_clear_input,
        chan_a_carrier_input, chan_b_carrier_input} & (dce ? 8'hfe : 8'hff), e);
      chk("clk", {4'h0, link_tx_clock_out, link_rx_clock_out, receive_clock_pins, chan_a_clock_pin_out},
        {4'h0, cdrv, dce ? cdrv[0] : link_rx_clock_in, link_tx_clock_in});
    end
    run = 1'b0;
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    run = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    role_is_dce = 1'b0;
    sync_jumper_fitted = 1'b0;
    test_mode_indication = 1'b0;
    int_source_select = 2'h0;
    mdrv = 8'h00;
    cdrv = 2'h0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    rd(A, 8'h00);
    wr(A, 8'h20);
    chk("loop", {5'h0, local_loopback_request, remote_loopback_request, chan_a_sync_input}, 8'h04);
    @(posedge clock);
    sync_jumper_fitted <= 1'b1;
    wr(A, 8'h10);
    chk("loop", {5'h0, local_loopback_request, remote_loopback_request, chan_a_sync_input}, 8'h03);
    rd(8'h05, 8'h00);
    @(posedge clock);
    test_mode_indication <= 1'b1;
    int_source_select <= sslc_pkg::INT_SEL_TEST_MODE;
    wr(A, 8'hd0);
    repeat (2) @(posedge clock);
    #1;
    chk("int", {7'h0, test_mode_interrupt}, 8'h01);
    rd(A, 8'h90);
    @(posedge clock);
    int_source_select <= 2'h2;
    clk_oe(8'h0c, 4'b0100);
    chk("int", {7'h0, test_mode_interrupt}, 8'h00);
    clk_oe(8'h00, 4'b1000);
    route(1'b0);
    @(posedge clock);
    role_is_dce <= 1'b1;
    repeat (4) @(posedge clock);
    clk_oe(8'h00, 4'b0100);
    clk_oe(8'h0c, 4'b0110);
    route(1'b1);
    rd(A, 8'h8c);
    wrrd(A, 8'h24, 8'ha4);
    wr(A, 8'h20);
    chk("loop", {5'h0, local_loopback_request, remote_loopback_request, chan_a_sync_input}, 8'h04);
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    rd(A, 8'h80);
    print_verdict();
  end
endmodule
